// *** rtl/gps_phy_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module gps_phy_core
    import gps_pkg::*;
#(
    parameter int RX_HALF = RX_HALF_CYCLES
) (
    input  wire logic        mclk_i,      // system clock 50 MHz
    input  wire logic        rst_n_i,     // sync reset, active low
    input  wire logic        gtx_clk_i,   // transmit clock pin from MAC
    input  wire logic        tx_en_i,     // transmit enable pin
    input  wire logic        tx_er_i,     // transmit error pin
    input  wire logic [7:0]  txd_i,       // transmit data pins
    output logic             rx_clk_o,    // receive clock to MAC
    output logic             rx_dv_o,     // receive data valid
    output logic             rx_er_o,     // receive error
    output logic [7:0]       rxd_o,       // receive data
    output logic             crs_o,       // carrier sense
    output logic             col_o,       // collision
    input  wire logic        loopback_i,  // loop transmit into receive
    input  wire logic        half_dup_i,  // half duplex operation
    output gps_sym_type      tx_kind_o,   // symbol kind to medium
    output logic [7:0]       tx_sym_o,    // symbol octet to medium
    output logic             tx_stb_o,    // pulse per sent symbol
    input  wire gps_sym_type med_kind_i,  // symbol kind from medium
    input  wire logic [7:0]  med_sym_i    // symbol octet from medium
);
    logic         gclk_s1, gclk_s2, gclk_s3;
    logic         en_s1, en_s2, er_s1, er_s2;
    logic [7:0]   txd_s1, txd_s2;
    logic         tx_tick;
    gps_path_type tx_state, next_tx_state;
    gps_sym_type  next_tx_kind;
    logic [7:0]   next_tx_sym;
    logic         tx_busy;

    logic         rx_rise, rx_fall;
    gps_sym_type  src_kind;
    logic [7:0]   src_sym;
    gps_path_type rx_state, next_rx_state;
    logic         next_dv, next_er, next_rx_busy, rx_busy;
    logic [7:0]   next_rxd;

    // pins cross into the system clock through two flops
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            gclk_s1 <= 1'b0;
            gclk_s2 <= 1'b0;
            gclk_s3 <= 1'b0;
            en_s1   <= 1'b0;
            en_s2   <= 1'b0;
            er_s1   <= 1'b0;
            er_s2   <= 1'b0;
            txd_s1  <= CODE_ZERO;
            txd_s2  <= CODE_ZERO;
        end else begin
            gclk_s1 <= gtx_clk_i;
            gclk_s2 <= gclk_s1;
            gclk_s3 <= gclk_s2;
            en_s1   <= tx_en_i;
            en_s2   <= en_s1;
            er_s1   <= tx_er_i;
            er_s2   <= er_s1;
            txd_s1  <= txd_i;
            txd_s2  <= txd_s1;
        end
    end

    assign tx_tick = gclk_s2 & ~gclk_s3;

    // transmit coder, one decision per rising transmit clock edge
    always_comb begin
        next_tx_state = PATH_IDLE;
        next_tx_kind  = SYM_IDLE;
        next_tx_sym   = CODE_ZERO;
        if (en_s2) begin
            next_tx_state = PATH_FRAME;
            next_tx_sym   = txd_s2;
            if (tx_state != PATH_FRAME && tx_state != PATH_TAIL)
                next_tx_kind = SYM_START;
            else if (er_s2)
                next_tx_kind = SYM_INVALID;
            else
                next_tx_kind = SYM_DATA;
        end else if (tx_state == PATH_FRAME) begin
            // delimiter closes the frame; error high opens an extension
            next_tx_kind  = SYM_END;
            next_tx_state = er_s2 ? PATH_EXT : PATH_IDLE;
        end else if (er_s2) begin
            case (tx_state)
                PATH_EXT: begin
                    if (txd_s2 == CODE_EXTEND) begin
                        next_tx_kind  = SYM_EXT;
                        next_tx_state = PATH_EXT;
                    end else if (txd_s2 == CODE_EXT_ERR) begin
                        next_tx_kind  = SYM_EXT_ERR;
                        next_tx_state = PATH_EXT;
                    end
                end
                PATH_IDLE: begin
                    if (txd_s2 == CODE_LPI)
                        next_tx_kind = SYM_LPI;
                end
                default: begin
                    next_tx_kind = SYM_IDLE;
                end
            endcase
        end
        // enable and error both low: data lines are never looked at
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tx_state  <= PATH_IDLE;
            tx_kind_o <= SYM_IDLE;
            tx_sym_o  <= CODE_ZERO;
            tx_stb_o  <= 1'b0;
        end else begin
            tx_stb_o <= tx_tick;
            if (tx_tick) begin
                tx_state  <= next_tx_state;
                tx_kind_o <= next_tx_kind;
                tx_sym_o  <= next_tx_sym;
            end
        end
    end

    assign tx_busy = (tx_state != PATH_IDLE);

    gps_rx_clk_gen #(
        .HALF_CYCLES(RX_HALF)
    ) u_rx_clk (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .rx_clk_o(rx_clk_o),
        .rise_o  (rx_rise),
        .fall_o  (rx_fall)
    );

    // medium feeds receive unless loopback is chosen
    assign src_kind = loopback_i ? tx_kind_o : med_kind_i;
    assign src_sym  = loopback_i ? tx_sym_o  : med_sym_i;

    always_comb begin
        next_dv       = 1'b0;
        next_er       = 1'b0;
        next_rxd      = CODE_ZERO;
        next_rx_state = PATH_IDLE;
        next_rx_busy  = 1'b0;
        case (src_kind)
            SYM_START: begin
                next_dv       = 1'b1;
                next_rxd      = CODE_PREAMBLE;
                next_rx_state = PATH_FRAME;
                next_rx_busy  = 1'b1;
            end
            SYM_DATA: begin
                if (rx_state == PATH_FRAME) begin
                    next_dv       = 1'b1;
                    next_rxd      = src_sym;
                    next_rx_state = PATH_FRAME;
                    next_rx_busy  = 1'b1;
                end
            end
            SYM_INVALID: begin
                next_er      = 1'b1;
                next_rx_busy = 1'b1;
                if (rx_state == PATH_FRAME) begin
                    next_dv       = 1'b1;
                    next_rxd      = src_sym;
                    next_rx_state = PATH_FRAME;
                end else begin
                    next_rxd = CODE_FALSE_CAR;
                end
            end
            SYM_END: begin
                if (rx_state == PATH_FRAME) begin
                    next_rx_state = PATH_TAIL;
                    next_rx_busy  = 1'b1;
                end
            end
            SYM_EXT, SYM_EXT_ERR: begin
                if (rx_state == PATH_TAIL || rx_state == PATH_EXT) begin
                    next_er       = 1'b1;
                    next_rxd      = (src_kind == SYM_EXT) ? CODE_EXTEND
                                                          : CODE_EXT_ERR;
                    next_rx_state = PATH_EXT;
                    next_rx_busy  = 1'b1;
                end
            end
            SYM_LPI: begin
                if (rx_state == PATH_IDLE) begin
                    next_er  = 1'b1;
                    next_rxd = CODE_LPI;
                end
            end
            default: begin
                next_rx_state = PATH_IDLE;
            end
        endcase
    end

    // launch on the falling edge so the MAC samples stable values
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rx_state <= PATH_IDLE;
            rx_dv_o  <= 1'b0;
            rx_er_o  <= 1'b0;
            rxd_o    <= CODE_ZERO;
            rx_busy  <= 1'b0;
        end else if (rx_fall) begin
            rx_state <= next_rx_state;
            rx_dv_o  <= next_dv;
            rx_er_o  <= next_er;
            rxd_o    <= next_rxd;
            rx_busy  <= next_rx_busy;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            crs_o <= 1'b0;
            col_o <= 1'b0;
        end else begin
            crs_o <= tx_busy | rx_busy;
            col_o <= half_dup_i & tx_busy & rx_busy;
        end
    end

    chk_idle_ignores_txd: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        tx_tick && !en_s2 && !er_s2 && tx_state == PATH_IDLE
        |=> tx_kind_o == SYM_IDLE && tx_sym_o == CODE_ZERO)
        else $error("transmit lines affected the medium while idle");

    chk_err_sends_invalid: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        tx_tick && en_s2 && er_s2 && tx_state == PATH_FRAME
        |=> tx_kind_o == SYM_INVALID && tx_stb_o)
        else $error("transmit error did not send invalid code");

    chk_drop_sends_end: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        tx_tick && !en_s2 && er_s2 && tx_state == PATH_FRAME
        |=> tx_kind_o == SYM_END && tx_state == PATH_EXT)
        else $error("end delimiter missing when enable fell");

    chk_ext_after_frame: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        $rose(rx_er_o && !rx_dv_o && rxd_o == CODE_EXTEND)
        |-> $past(rx_state) == PATH_TAIL || $past(rx_state) == PATH_EXT)
        else $error("receive extension not directly after a frame");

    chk_rx_steady: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        !rx_fall |=> $stable(rx_dv_o) && $stable(rxd_o) && $stable(rx_er_o))
        else $error("receive outputs moved off the clock edge");

    chk_rx_dv_start: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        rx_fall && src_kind == SYM_START
        |=> rx_dv_o && rxd_o == CODE_PREAMBLE && !rx_er_o)
        else $error("receive valid not raised on first octet");

    chk_no_loopback: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        rx_fall && !loopback_i && med_kind_i == SYM_DATA
        && rx_state == PATH_FRAME |=> rxd_o == $past(med_sym_i))
        else $error("receive data not taken from the medium");

    chk_rx_err_report: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        rx_fall && src_kind == SYM_INVALID |=> rx_er_o)
        else $error("receive error not reported");

    chk_crs_tracks_busy: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        ##1 crs_o == $past(tx_busy || rx_busy))
        else $error("carrier sense disagrees with path activity");

    chk_crs_in_collision: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        col_o |-> crs_o)
        else $error("carrier sense low during collision");

    chk_col_follows: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        half_dup_i && tx_busy && rx_busy |=> col_o)
        else $error("collision not raised");
endmodule : gps_phy_core
`default_nettype wire

// *** rtl/gps_pkg.sv ***
// Functional notes
// - receive clock keeps its period and both phases whole; no edge gap grows
// - transmit lines follow transmit clock; ignored while enable and error low
// - carrier extension is honoured only directly after a frame, both ways
// - transmit error during enable sends an invalid code-group, except on the first octet, which sends start
// - enable falling together with error rising sends end-of-packet delimiter
// - the transmit error input is always present at the interface
// - receive valid spans first to last octet; receive outputs follow rx clock
// - transmit data reaches receive lines only in loopback mode
// - receive error reports errors found in the received stream
// - carrier sense high while either path is busy, low when both idle
// - carrier sense stays high throughout a collision
// - collision is raised and held while the collision lasts
package gps_pkg;
    localparam int MCLK_MHZ         = 50;
    localparam int RX_CLK_PERIOD_NS = 160;
    localparam int RX_HALF_CYCLES   = (RX_CLK_PERIOD_NS * MCLK_MHZ) / 2000;

    localparam logic [7:0] CODE_PREAMBLE  = 8'h55;
    localparam logic [7:0] CODE_EXTEND    = 8'h0F;
    localparam logic [7:0] CODE_EXT_ERR   = 8'h1F;
    localparam logic [7:0] CODE_LPI       = 8'h01;
    localparam logic [7:0] CODE_FALSE_CAR = 8'h0E;
    localparam logic [7:0] CODE_ZERO      = 8'h00;

    // symbols exchanged with the medium coder
    typedef enum logic [2:0] {
        SYM_IDLE, SYM_START, SYM_DATA, SYM_END,
        SYM_INVALID, SYM_EXT, SYM_EXT_ERR, SYM_LPI
    } gps_sym_type;

    typedef enum logic [1:0] {
        PATH_IDLE, PATH_FRAME, PATH_TAIL, PATH_EXT
    } gps_path_type;
endpackage : gps_pkg

// *** rtl/gps_rx_clk_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module gps_rx_clk_gen
    import gps_pkg::*;
#(
    parameter int HALF_CYCLES = RX_HALF_CYCLES
) (
    input  wire logic mclk_i,   // system clock
    input  wire logic rst_n_i,  // sync reset, active low
    output logic      rx_clk_o, // receive clock out
    output logic      rise_o,   // pulse with rising edge
    output logic      fall_o    // pulse with falling edge
);
    localparam logic [7:0] LAST = 8'(HALF_CYCLES - 1);

    logic [7:0] cnt;

    // fixed divider: phases never shrink or stretch on any path
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cnt      <= 8'h00;
            rx_clk_o <= 1'b0;
            rise_o   <= 1'b0;
            fall_o   <= 1'b0;
        end else if (cnt == LAST) begin
            cnt      <= 8'h00;
            rx_clk_o <= ~rx_clk_o;
            rise_o   <= ~rx_clk_o;
            fall_o   <= rx_clk_o;
        end else begin
            cnt      <= cnt + 8'h01;
            rise_o   <= 1'b0;
            fall_o   <= 1'b0;
        end
    end

    chk_clk_high_phase: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        $rose(rx_clk_o) |-> rx_clk_o[*4] ##1 !rx_clk_o)
        else $error("rx clock high phase not four cycles");

    chk_clk_low_phase: assert property (
        @(posedge mclk_i) disable iff (!rst_n_i)
        $fell(rx_clk_o) |-> !rx_clk_o[*4] ##1 rx_clk_o)
        else $error("rx clock low phase not four cycles");
endmodule : gps_rx_clk_gen
`default_nettype wire

// *** testbench/gps_mac_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module gps_mac_model #(
    parameter int WAKE_TIME = 2  // resolved transmit wake time, in octets
) (
    output logic       gtx_clk_o, // transmit clock, runs only per octet
    output logic       tx_en_o,   // transmit enable
    output logic       tx_er_o,   // transmit error
    output logic [7:0] txd_o      // transmit data
);
    initial begin
        gtx_clk_o = 1'b0;
        tx_en_o   = 1'b0;
        tx_er_o   = 1'b0;
        txd_o     = 8'h00;
    end

    // lines change at the falling clock edge, one rising edge per octet
    task automatic octet(input logic en, input logic er, input logic [7:0] d);
        tx_en_o = en;
        tx_er_o = er;
        txd_o   = (en || er) ? d : ~txd_o;
        #80 gtx_clk_o = 1'b1;
        #80 gtx_clk_o = 1'b0;
    endtask : octet

    task automatic frame(input logic [7:0] first, input int n,
                         input logic bad, input logic ext);
        for (int i = 0; i < 7; i++) begin
            octet(1'b1, 1'b0, 8'h55);
        end
        octet(1'b1, 1'b0, 8'hD5);
        for (int i = 0; i < n; i++) begin
            octet(1'b1, bad && i == 1, first + 8'(i));
        end
        octet(1'b0, ext, 8'h0F);
    endtask : frame

    // clock keeps running through nine low-power octets before it may stop;
    // the wake timer then runs its terminal count of idle octets
    task automatic lpi;
        repeat (9) octet(1'b0, 1'b1, 8'h01);
        repeat (WAKE_TIME) octet(1'b0, 1'b0, 8'h00);
    endtask : lpi
endmodule : gps_mac_model
`default_nettype wire

// *** testbench/tb_gps_phy_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_gps_phy_core import gps_pkg::*;;
    logic        mclk_i   = 1'b0;
    logic        rst_n_i  = 1'b0;
    logic        gtx_clk;
    logic        tx_en;
    logic        tx_er;
    logic [7:0]  txd;
    logic        rx_clk;
    logic        rx_dv;
    logic        rx_er;
    logic [7:0]  rxd;
    logic        crs;
    logic        col;
    logic        loopback = 1'b0;
    logic        half_dup = 1'b0;
    gps_sym_type tx_kind;
    logic [7:0]  tx_sym;
    logic        tx_stb;
    gps_sym_type med_kind = SYM_IDLE;
    logic [7:0]  med_sym  = 8'h00;
    int          fail_count = 0;
    int          n_tests    = 0;
    int          gap        = 0;
    logic        seen       = 1'b0;
    logic        clk_q      = 1'b0;
    logic [9:0]  rx_q       = 10'h000;
    logic [11:0] expq[$];
    logic [10:0] txq[$];

    localparam int WAKE_TIME = 2;

    always #10 mclk_i = ~mclk_i;

    gps_phy_core u_gps_phy_core (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .gtx_clk_i(gtx_clk),
        .tx_en_i(tx_en), .tx_er_i(tx_er), .txd_i(txd), .rx_clk_o(rx_clk),
        .rx_dv_o(rx_dv), .rx_er_o(rx_er), .rxd_o(rxd), .crs_o(crs),
        .col_o(col), .loopback_i(loopback), .half_dup_i(half_dup),
        .tx_kind_o(tx_kind), .tx_sym_o(tx_sym), .tx_stb_o(tx_stb),
        .med_kind_i(med_kind), .med_sym_i(med_sym));

    gps_mac_model #(.WAKE_TIME(WAKE_TIME)) u_gps_mac_model (
        .gtx_clk_o(gtx_clk), .tx_en_o(tx_en), .tx_er_o(tx_er), .txd_o(txd));

    task automatic final_report;
        if (fail_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    task automatic fail(input string m);
        fail_count++;
        $display("[FAIL] %0t %s", $time, m);
    endtask : fail

    task automatic check_flag(input logic got, input logic exp, input string m);
        n_tests++;
        if (got !== exp)
            fail(m);
    endtask : check_flag

    task automatic check_rx(input logic dv, input logic er,
                            input logic [7:0] d, input logic use_d);
        n_tests++;
        if (rx_dv !== dv || rx_er !== er || (use_d && rxd !== d))
            fail("receive outputs");
    endtask : check_rx

    task automatic check_tx;
        logic [11:0] e;
        logic [10:0] g;
        check_flag(txq.size() == expq.size(), 1'b1, "tx symbol count");
        while (expq.size() > 0 && txq.size() > 0) begin
            e = expq.pop_front();
            g = txq.pop_front();
            n_tests++;
            if (g[10:8] !== e[10:8] || (e[11] && g[7:0] !== e[7:0]))
                fail("tx symbol");
        end
        txq.delete();
        expq.delete();
    endtask : check_tx

    task automatic ex(input gps_sym_type k, input logic [7:0] s, input logic u);
        expq.push_back({u, k, s});
    endtask : ex

    task automatic ex_pre;
        ex(SYM_START, 8'h55, 1'b1);
        for (int i = 0; i < 7; i++) begin
            ex(SYM_DATA, (i < 6) ? 8'h55 : 8'hD5, 1'b1);
        end
    endtask : ex_pre

    task automatic rx_step(input gps_sym_type k, input logic [7:0] s);
        @(posedge rx_clk);
        @(negedge mclk_i);
        med_kind = k;
        med_sym  = s;
        @(negedge rx_clk);
        @(negedge mclk_i);
        @(negedge mclk_i);
    endtask : rx_step

    task automatic test_tx_frame;
        ex_pre;
        for (int i = 0; i < 3; i++) begin
            ex(SYM_DATA, 8'h10 + 8'(i), 1'b1);
        end
        ex(SYM_END, 8'h00, 1'b0);
        ex(SYM_IDLE, 8'h00, 1'b1);
        u_gps_mac_model.frame(8'h10, 3, 1'b0, 1'b0);
        u_gps_mac_model.octet(1'b0, 1'b0, 8'hAA);
        repeat (8) @(negedge mclk_i);
        check_tx;
    endtask : test_tx_frame

    task automatic test_tx_error;
        gps_sym_type k[8] = '{SYM_DATA, SYM_INVALID, SYM_END, SYM_EXT,
            SYM_EXT_ERR, SYM_IDLE, SYM_IDLE, SYM_LPI};
        logic [7:0] c[4] = '{8'h0F, 8'h1F, 8'h33, 8'h0F};
        ex_pre;
        for (int i = 0; i < 8; i++) begin
            ex(k[i], (i == 0) ? 8'h20 : 8'h00, i == 0);
        end
        repeat (8) ex(SYM_LPI, 8'h00, 1'b0);
        repeat (WAKE_TIME) ex(SYM_IDLE, 8'h00, 1'b1);
        u_gps_mac_model.frame(8'h20, 2, 1'b1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            u_gps_mac_model.octet(1'b0, 1'b1, c[i]);
        end
        u_gps_mac_model.lpi;
        repeat (8) @(negedge mclk_i);
        check_tx;
    endtask : test_tx_error

    task automatic test_rx;
        gps_sym_type k[12] = '{SYM_START, SYM_DATA, SYM_INVALID, SYM_END,
            SYM_EXT, SYM_EXT_ERR, SYM_IDLE, SYM_EXT, SYM_DATA, SYM_INVALID,
            SYM_LPI, SYM_IDLE};
        logic [7:0] s[12] = '{8'h00, 8'hAB, 8'h3C, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'hCD, 8'h00, 8'h00, 8'h00};
        logic [9:0] e[12] = '{10'h255, 10'h2AB, 10'h33C, 10'h000, 10'h10F,
            10'h11F, 10'h000, 10'h000, 10'h000, 10'h10E, 10'h101, 10'h000};
        int ext_seen = 0;
        for (int i = 0; i < 12; i++) begin
            rx_step(k[i], s[i]);
            check_rx(e[i][9], e[i][8], e[i][7:0], i != 3);
            if (!rx_dv && rx_er && (rxd === 8'h0F || rxd === 8'h1F))
                ext_seen++;
        end
        check_flag(ext_seen == 2, 1'b1, "extend count");
    endtask : test_rx

    task automatic test_crs;
        half_dup = 1'b1;
        u_gps_mac_model.octet(1'b1, 1'b0, 8'h55);
        repeat (20) @(negedge mclk_i);
        check_flag(crs, 1'b1, "crs on transmit");
        check_flag(col, 1'b0, "col with one path");
        check_flag(rx_dv, 1'b0, "loop without mode");
        loopback = 1'b1;
        @(negedge rx_clk);
        repeat (2) @(negedge mclk_i);
        check_rx(1'b1, 1'b0, 8'h55, 1'b1);
        loopback = 1'b0;
        rx_step(SYM_START, 8'h00);
        repeat (3) @(negedge mclk_i);
        check_flag(col, 1'b1, "col on collision");
        rx_step(SYM_DATA, 8'h77);
        check_flag(col & crs, 1'b1, "col held");
        u_gps_mac_model.octet(1'b0, 1'b0, 8'h00);
        repeat (12) @(negedge mclk_i);
        check_flag(col, 1'b0, "col after tx end");
        check_flag(crs, 1'b1, "crs on receive");
        rx_step(SYM_END, 8'h00);
        rx_step(SYM_IDLE, 8'h00);
        repeat (3) @(negedge mclk_i);
        check_flag(crs, 1'b0, "crs both idle");
        half_dup = 1'b0;
    endtask : test_crs

    // receive clock half periods and output change moments
    always @(negedge mclk_i) begin
        if (rst_n_i !== 1'b1) begin
            seen <= 1'b0;
            gap  <= 0;
        end else if (rx_clk !== clk_q) begin
            if (seen)
                check_flag(gap == 4, 1'b1, "rx clock phase");
            seen <= 1'b1;
            gap  <= 1;
        end else begin
            gap <= gap + 1;
        end
        if (rst_n_i === 1'b1 && {rx_dv, rx_er, rxd} !== rx_q)
            check_flag(rx_clk === 1'b0 && gap == 1, 1'b1, "rx timing");
        clk_q <= rx_clk;
        rx_q  <= {rx_dv, rx_er, rxd};
    end

    always @(negedge mclk_i) begin
        if (tx_stb === 1'b1)
            txq.push_back({tx_kind, tx_sym});
    end

    initial begin
        #300000;
        fail("timeout");
        final_report;
    end

    initial begin
        repeat (6) @(posedge mclk_i);
        @(negedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (8) @(negedge mclk_i);
        test_tx_frame;
        test_tx_error;
        test_rx;
        test_crs;
        final_report;
    end
endmodule : tb_gps_phy_core
`default_nettype wire
